// [src/iss_pkg.sv]
// Constants, register map and state type of the split microframe scheduler
package iss_pkg;
   localparam int NUF = 8;
   localparam int CODE_W = 3;
   localparam int CNT_W = 8;
   localparam int FRM_W = 5;
   localparam int UF_W = 3;

   // Wishbone byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_MASK = 8'h04;
   localparam logic [7:0] A_RES = 8'h08;
   localparam logic [7:0] A_CNT_LO = 8'h0C;
   localparam logic [7:0] A_CNT_HI = 8'h10;
   localparam logic [7:0] A_FLAGS = 8'h14;
   localparam logic [7:0] A_IRQ_ST = 8'h18;
   localparam logic [7:0] A_IRQ_CLR = 8'h1C;
   localparam logic [7:0] A_IRQ_EN = 8'h20;

   // CTRL fields
   localparam int B_ACTIVE = 0;
   localparam int B_IS_IN = 1;
   localparam int B_UFRM_LO = 8;
   localparam int B_FRM_LO = 11;
   // MASK fields
   localparam int B_SSM_LO = 0;
   localparam int B_CSM_LO = 8;
   // RESULT word: codes above the start mask
   localparam int B_CODE_LO = 8;
   // FLAGS fields
   localparam int B_HALT = 0;
   localparam int B_BABBLE = 1;
   localparam int B_XERR = 2;
   localparam int B_SC = 3;

   // Result code bits
   localparam int C_XERR = 0;
   localparam int C_BABBLE = 1;
   localparam int C_UNDERRUN = 2;
   localparam logic [2:0] CODE_IN_KEEP = 3'h3;
   localparam logic [2:0] CODE_OUT_KEEP = 3'h5;

   // Interrupt events
   localparam int IRQ_W = 4;
   localparam int E_DONE = 0;
   localparam int E_ERR = 1;
   localparam int E_HALT = 2;
   localparam int E_RETIRE = 3;

   // Start splits for IN only below this microframe
   localparam logic [2:0] IN_SS_LIMIT = 3'h4;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SS,
      ST_CS
   } iss_state_t;
endpackage

// [src/iss_sched.sv]
// Isochronous split microframe scheduler with Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module iss_sched (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        sof_i,
   input  wire logic [4:0]  bus_frame_i,
   input  wire logic [2:0]  bus_uframe_i,
   output logic             split_req_o,
   output logic             split_cs_o,
   output logic             split_in_o,
   output logic      [2:0]  split_uframe_o,
   input  wire logic        split_done_i,
   input  wire logic [2:0]  split_result_i,
   input  wire logic        split_halt_i,
   input  wire logic [7:0]  split_count_i,
   output logic             irq_o
);
   iss_pkg::iss_state_t state_reg;
   iss_pkg::iss_state_t state_next;

   logic        ack_reg;
   logic [31:0] dat_reg;
   logic        active_reg;
   logic        is_in_reg;
   logic [7:0]  uframe_reg;
   logic [7:0]  ssm_reg;
   logic [7:0]  ssm_next;
   logic [7:0]  csm_reg;
   logic [7:0]  csm_next;
   logic [2:0]  cur_reg;
   logic        halt_reg;
   logic        sc_reg;
   logic [3:0]  ist_reg;
   logic [3:0]  ien_reg;
   logic        irq_reg;
   logic        req_reg;
   logic [2:0]  code_reg [0:7];
   logic [7:0]  cnt_reg [0:7];

   // Bus decode
   wire         acc = cyc_i & stb_i & ~ack_reg;
   wire         wr = acc & we_i;
   wire [31:0]  bmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                         {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire [31:0]  wdat = dat_i & bmask;
   wire         wr_ctrl = wr && (adr_i == iss_pkg::A_CTRL);
   wire         wr_mask = wr && (adr_i == iss_pkg::A_MASK);
   wire         wr_iclr = wr && (adr_i == iss_pkg::A_IRQ_CLR);
   wire         wr_ien = wr && (adr_i == iss_pkg::A_IRQ_EN);

   // Packed result word and count words
   logic [23:0] codes;
   logic [7:0]  any_xerr;
   logic [7:0]  any_babble;
   genvar g;
   generate
      for (g = 0; g < iss_pkg::NUF; g = g + 1)
      begin : g_pack
         assign codes[g*3 +: 3] = code_reg[g];
         assign any_xerr[g] = code_reg[g][iss_pkg::C_XERR];
         assign any_babble[g] = code_reg[g][iss_pkg::C_BABBLE];
      end
   endgenerate

   wire [31:0] res_word = {codes, ssm_reg};
   wire [31:0] cnt_lo = {cnt_reg[3], cnt_reg[2], cnt_reg[1], cnt_reg[0]};
   wire [31:0] cnt_hi = {cnt_reg[7], cnt_reg[6], cnt_reg[5], cnt_reg[4]};
   wire        babble_flag = |any_babble;
   wire        xerr_flag = |any_xerr;
   wire [31:0] flags_word = {28'h0000000, sc_reg, xerr_flag,
                             babble_flag, halt_reg};
   wire [31:0] ctrl_word = {16'h0000, uframe_reg, 6'h00,
                            is_in_reg, active_reg};
   wire [31:0] mask_word = {16'h0000, csm_reg, ssm_reg};
   wire [31:0] ist_word = {28'h0000000, ist_reg};
   wire [31:0] ien_word = {28'h0000000, ien_reg};

   logic [31:0] rdat;
   always_comb
   begin
      if (adr_i == iss_pkg::A_CTRL)
         rdat = ctrl_word;
      else if (adr_i == iss_pkg::A_MASK)
         rdat = mask_word;
      else if (adr_i == iss_pkg::A_RES)
         rdat = res_word;
      else if (adr_i == iss_pkg::A_CNT_LO)
         rdat = cnt_lo;
      else if (adr_i == iss_pkg::A_CNT_HI)
         rdat = cnt_hi;
      else if (adr_i == iss_pkg::A_FLAGS)
         rdat = flags_word;
      else if (adr_i == iss_pkg::A_IRQ_ST)
         rdat = ist_word;
      else if (adr_i == iss_pkg::A_IRQ_EN)
         rdat = ien_word;
      else
         rdat = 32'h00000000;
   end

   // Microframe selection
   wire [4:0] desc_frame = uframe_reg[7:3];
   wire       fmatch = (desc_frame == bus_frame_i);
   wire       ss_ok = ~is_in_reg
                      | (bus_uframe_i < iss_pkg::IN_SS_LIMIT);
   wire       hit_ss = ssm_reg[bus_uframe_i] & fmatch & ss_ok;
   wire       hit_cs = csm_reg[bus_uframe_i] & fmatch & is_in_reg;
   wire       start = (state_reg == iss_pkg::ST_IDLE) & sof_i & active_reg;
   wire       go_ss = start & hit_ss;
   wire       go_cs = start & ~hit_ss & hit_cs;
   wire       ss_end = (state_reg == iss_pkg::ST_SS) & split_done_i;
   wire       cs_end = (state_reg == iss_pkg::ST_CS) & split_done_i;
   wire       any_end = ss_end | cs_end;
   wire       chain_cs = ss_end & is_in_reg & csm_reg[cur_reg];
   wire       retire = active_reg & (state_reg == iss_pkg::ST_IDLE)
                       & (ssm_reg == 8'h00) & (csm_reg == 8'h00);
   wire [2:0] keep = is_in_reg ? iss_pkg::CODE_IN_KEEP
                               : iss_pkg::CODE_OUT_KEEP;
   wire [2:0] code_in = split_result_i & keep;
   wire [7:0] cur_hot = 8'h01 << cur_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         iss_pkg::ST_IDLE:
            if (go_ss)
               state_next = iss_pkg::ST_SS;
            else if (go_cs)
               state_next = iss_pkg::ST_CS;
         iss_pkg::ST_SS:
            if (chain_cs)
               state_next = iss_pkg::ST_CS;
            else if (ss_end)
               state_next = iss_pkg::ST_IDLE;
         iss_pkg::ST_CS:
            if (cs_end)
               state_next = iss_pkg::ST_IDLE;
         default:
            state_next = iss_pkg::ST_IDLE;
      endcase
   end

   // Hardware clear after processing; a software set in the same cycle wins
   wire [7:0] ss_clr = ss_end ? cur_hot : 8'h00;
   wire [7:0] cs_clr = cs_end ? cur_hot : 8'h00;
   wire [7:0] ss_set = wr_mask ? wdat[iss_pkg::B_SSM_LO +: 8] : 8'h00;
   wire [7:0] cs_set = wr_mask ? wdat[iss_pkg::B_CSM_LO +: 8] : 8'h00;
   assign ssm_next = (ssm_reg & ~ss_clr) | ss_set;
   assign csm_next = (csm_reg & ~cs_clr) | cs_set;

   wire [3:0] events = {retire, any_end & split_halt_i,
                        any_end & (|code_in), any_end};
   wire [3:0] iclr = wr_iclr ? wdat[3:0] : 4'h0;

   // Bus answer and interrupt state; an event beats a clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
         ist_reg <= 4'h0;
         ien_reg <= 4'h0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= acc;
         if (acc)
            dat_reg <= rdat;
         ist_reg <= (ist_reg & ~iclr) | events;
         if (wr_ien)
            ien_reg <= wdat[3:0];
         irq_reg <= |(ist_reg & ien_reg);
      end
   end

   // Mask bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ssm_reg <= 8'h00;
         csm_reg <= 8'h00;
      end
      else
      begin
         ssm_reg <= ssm_next;
         csm_reg <= csm_next;
      end
   end

   // Split engine; request stays up across a chained complete split
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= iss_pkg::ST_IDLE;
         cur_reg <= 3'h0;
         req_reg <= 1'b0;
         sc_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (start)
            cur_reg <= bus_uframe_i;
         req_reg <= (state_next != iss_pkg::ST_IDLE) & ~any_end
                    | chain_cs;
         if (go_ss)
            sc_reg <= 1'b0;
         else if (go_cs | chain_cs)
            sc_reg <= 1'b1;
      end
   end

   // Control register; hardware drops active once both masks are empty
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active_reg <= 1'b0;
         is_in_reg <= 1'b0;
         uframe_reg <= 8'h00;
         halt_reg <= 1'b0;
      end
      else
      begin
         if (wr_ctrl && sel_i[0])
         begin
            active_reg <= wdat[iss_pkg::B_ACTIVE];
            is_in_reg <= wdat[iss_pkg::B_IS_IN];
         end
         else if (retire)
            active_reg <= 1'b0;
         if (wr_ctrl && sel_i[1])
            uframe_reg <= wdat[iss_pkg::B_UFRM_LO +: 8];
         if (any_end && split_halt_i)
            halt_reg <= 1'b1;
         else if (wr_ctrl && wdat[iss_pkg::B_ACTIVE])
            halt_reg <= 1'b0;
      end
   end

   // Per microframe result and count fields
   generate
      for (g = 0; g < iss_pkg::NUF; g = g + 1)
      begin : g_uf
         wire mine = (cur_reg == 3'(g));
         wire put_code = any_end & mine;
         wire put_cnt = put_code & is_in_reg;
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               code_reg[g] <= 3'h0;
               cnt_reg[g] <= 8'h00;
            end
            else
            begin
               if (put_code)
                  code_reg[g] <= code_in;
               if (put_cnt)
                  cnt_reg[g] <= split_count_i;
            end
         end
      end
   endgenerate

   // Outputs
   logic       cs_out_reg;
   logic [2:0] uf_out_reg;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cs_out_reg <= 1'b0;
         uf_out_reg <= 3'h0;
      end
      else
      begin
         cs_out_reg <= (state_next == iss_pkg::ST_CS);
         if (start)
            uf_out_reg <= bus_uframe_i;
      end
   end

   assign dat_o = dat_reg;
   assign ack_o = ack_reg;
   assign irq_o = irq_reg;
   assign split_req_o = req_reg;
   assign split_cs_o = cs_out_reg;
   assign split_in_o = is_in_reg;
   assign split_uframe_o = uf_out_reg;
endmodule
`default_nettype wire

// [sim/iss_tt_model.sv]
// Behavioural translator side that answers split requests
`timescale 1ns/1ps
`default_nettype none
module iss_tt_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       req_i,
   input  wire logic [3:0] wait_i,
   input  wire logic [2:0] res_i,
   input  wire logic       halt_i,
   input  wire logic [7:0] cnt_i,
   output logic            done_o,
   output logic      [2:0] res_o,
   output logic            halt_o,
   output logic      [7:0] cnt_o
);
   logic [3:0] n_reg;
   // Junk outside the done cycle so stale values cannot pass
   assign res_o  = done_o ? res_i : ~res_i;
   assign halt_o = done_o ? halt_i : ~halt_i;
   assign cnt_o  = done_o ? cnt_i : ~cnt_i;
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !req_i || done_o)
      begin
         n_reg  <= 4'h0;
         done_o <= 1'h0;
      end
      else
      begin
         n_reg  <= n_reg + 4'h1;
         done_o <= (n_reg == wait_i);
      end
   end
endmodule
`default_nettype wire

// [sim/iss_sched_chk.sv]
// Port checker for the split scheduler
`timescale 1ns/1ps
`default_nettype none
module iss_sched_chk (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       ack_o,
   input wire logic       sof_i,
   input wire logic [2:0] bus_uframe_i,
   input wire logic       split_req_o,
   input wire logic       split_cs_o,
   input wire logic       split_in_o,
   input wire logic [2:0] split_uframe_o,
   input wire logic       split_done_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("bad ack");
   property p_uf; $rose(split_req_o) |-> split_uframe_o == $past(bus_uframe_i);
   endproperty
   a_uf: assert property (p_uf) else $error("wrong uframe");
   property p_cause; $rose(split_req_o) |-> $past(sof_i); endproperty
   a_cause: assert property (p_cause) else $error("split w/o sof");
   property p_in_lim;
      split_req_o && split_in_o && !split_cs_o |-> split_uframe_o < 3'h4;
   endproperty
   a_in_lim: assert property (p_in_lim) else $error("late IN ss");
   property p_cs_in; split_cs_o |-> split_in_o; endproperty
   a_cs_in: assert property (p_cs_in) else $error("cs on OUT");
   property p_hold;
      split_req_o && !split_done_i |=> split_req_o && $stable(split_uframe_o);
   endproperty
   a_hold: assert property (p_hold) else $error("req dropped");
   property p_end; split_req_o && split_done_i && !split_in_o |=> !split_req_o;
   endproperty
   a_end: assert property (p_end) else $error("OUT req stuck");
   property p_cs_end;
      split_req_o && split_done_i && split_cs_o |=> !split_req_o;
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("cs stuck");
   property p_cs_same;
      split_req_o && split_done_i && split_in_o
         |=> !split_req_o || split_cs_o && $stable(split_uframe_o);
   endproperty
   a_cs_same: assert property (p_cs_same) else $error("bad cs");
endmodule
bind iss_sched iss_sched_chk iss_sched_chk_inst (.clk_i, .rst_i, .cyc_i,
   .stb_i, .ack_o, .sof_i, .bus_uframe_i, .split_req_o, .split_cs_o,
   .split_in_o, .split_uframe_o, .split_done_i);
`default_nettype wire

// [sim/iss_sched_tb.sv]
// Register-level bench for the split scheduler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module iss_sched_tb;
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc_i = 1'h0;
   logic        stb_i = 1'h0;
   logic        we_i = 1'h0;
   logic        sof_i = 1'h0;
   logic        m_halt = 1'h0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [4:0]  bus_frame_i = 5'h00;
   logic [2:0]  bus_uframe_i = 3'h0;
   logic [3:0]  m_wait = 4'h0;
   logic [2:0]  m_res = 3'h0;
   logic [7:0]  m_cnt = 8'h00;
   logic [31:0] dat_o;
   logic [7:0]  split_count_i;
   logic [2:0]  split_uframe_o;
   logic [2:0]  split_result_i;
   logic        ack_o, split_req_o, split_cs_o, split_in_o;
   logic        split_done_i, split_halt_i, irq_o;
   int          n_fail = 0;
   int          checks_done = 0;
   iss_sched iss_sched_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .sof_i, .bus_frame_i, .bus_uframe_i,
      .split_req_o, .split_cs_o, .split_in_o, .split_uframe_o,
      .split_done_i, .split_result_i, .split_halt_i, .split_count_i, .irq_o);
   iss_tt_model iss_tt_model_inst (.clk_i, .rst_i, .req_i(split_req_o),
      .wait_i(m_wait), .res_i(m_res), .halt_i(m_halt), .cnt_i(m_cnt),
      .done_o(split_done_i), .res_o(split_result_i), .halt_o(split_halt_i),
      .cnt_o(split_count_i));
   always #50 clk_i = ~clk_i;
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      k = 0;
      do @(posedge clk_i); while (ack_o !== 1'h1 && k++ < 20);
      q = dat_o;
      if (ack_o !== 1'h1) n_fail++;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      we_i <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'h1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'h0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   // Waits out the whole split, start and complete alike
   task automatic usf(input logic [4:0] f, input logic [2:0] u);
      int k;
      @(posedge clk_i);
      sof_i <= 1'h1;
      bus_frame_i <= f;
      bus_uframe_i <= u;
      @(posedge clk_i);
      sof_i <= 1'h0;
      @(posedge clk_i);
      k = 0;
      while (split_req_o === 1'h1 && k++ < 200) @(posedge clk_i);
      if (split_req_o === 1'h1) n_fail++;
   endtask
   task automatic conclude();
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #2000000;
      n_fail++;
      conclude();
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(iss_pkg::A_MASK, 32'h0);
      rd(8'h30, 32'h0);
      // OUT, frame 3, start splits in microframes 0 and 2
      wr(iss_pkg::A_IRQ_EN, 32'hF);
      wr(iss_pkg::A_MASK, 32'h05);
      wr(iss_pkg::A_CTRL, 32'h1801);
      m_res <= 3'h7;
      m_halt <= 1'h1;
      m_cnt <= 8'hAA;
      usf(5'h03, 3'h1);
      usf(5'h05, 3'h0);
      rd(iss_pkg::A_MASK, 32'h05);
      usf(5'h03, 3'h0);
      m_res <= 3'h2;
      m_halt <= 1'h0;
      usf(5'h03, 3'h2);
      rd(iss_pkg::A_RES, 32'h500);
      rd(iss_pkg::A_FLAGS, 32'h5);
      rd(iss_pkg::A_CTRL, 32'h1800);
      `CHK(irq_o, 1'h1)
      wr(iss_pkg::A_IRQ_CLR, 32'hF);
      rd(iss_pkg::A_IRQ_ST, 32'h0);
      `CHK(irq_o, 1'h0)
      // IN, slow answers, start in 1, complete in 1 and 3
      wr(iss_pkg::A_IRQ_EN, 32'h0);
      wr(iss_pkg::A_MASK, 32'h0A02);
      wr(iss_pkg::A_CTRL, 32'h3);
      m_wait <= 4'h5;
      m_res <= 3'h6;
      m_cnt <= 8'h11;
      usf(5'h00, 3'h1);
      m_res <= 3'h1;
      m_cnt <= 8'h33;
      usf(5'h00, 3'h3);
      rd(iss_pkg::A_MASK, 32'h0);
      rd(iss_pkg::A_RES, 32'h21500);
      rd(iss_pkg::A_CNT_LO, 32'h33001100);
      rd(iss_pkg::A_CNT_HI, 32'h0);
      rd(iss_pkg::A_FLAGS, 32'hE);
      `CHK(irq_o, 1'h0)
      rd(iss_pkg::A_IRQ_ST, 32'hB);
      wr(iss_pkg::A_IRQ_EN, 32'h1);
      @(posedge clk_i);
      rd(iss_pkg::A_IRQ_EN, 32'h1);
      `CHK(irq_o, 1'h1)
      wr(iss_pkg::A_IRQ_CLR, 32'hF);
      rd(iss_pkg::A_IRQ_ST, 32'h0);
      `CHK(irq_o, 1'h0)
      // OUT ignores the complete mask
      wr(iss_pkg::A_MASK, 32'h0100);
      wr(iss_pkg::A_CTRL, 32'h1);
      usf(5'h00, 3'h0);
      rd(iss_pkg::A_MASK, 32'h0100);
      rd(iss_pkg::A_CTRL, 32'h1);
      conclude();
   end
endmodule
`default_nettype wire
